// ### tmr2_timer.sv
// 16-bit timer with two compare outputs and two capture inputs
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "tmr2_params.svh"
module tmr2_timer
    import tmr2_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic [1:0] cap_pin_i,
    output logic [1:0] cmp_out_o
);
    tmr2_core_t st_r;
    tmr2_core_t st_nxt;
    tmr2_cap_if cap_if[2] ();
    logic [1:0] cap_evt;
    tmr2_word_t [1:0] cap_val;
    logic wrap;
    logic [6:0] evt;
    logic [1:0] match;
    tmr2_word_t rd_val;

    // Capture channels
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_cap
            assign cap_if[g].filt = st_r.cap_filt[g];
            assign cap_if[g].edge_sel = st_r.cap_edge[g];
            assign cap_if[g].count = st_r.count;
            assign cap_evt[g] = cap_if[g].event_p;
            assign cap_val[g] = cap_if[g].value;
            tmr2_capture #(
                .FILT_LEN(`TMR2_FILT_LEN)
            ) u_cap (
                .mclk_i(mclk_i),
                .nrst_i(nrst_i),
                .pin_i(cap_pin_i[g]),
                .bus(cap_if[g].chan)
            );
        end
    endgenerate

    // Register read mux, reserved bits as zero
    always_comb
    begin
        rd_val = '0;
        case (addr_i)
            `TMR2_OFS_COUNT: rd_val = st_r.count; // RULE1
            `TMR2_OFS_CAP0: rd_val = cap_val[0]; // RULE9
            `TMR2_OFS_CAP1: rd_val = cap_val[1]; // RULE9
            `TMR2_OFS_TOP: rd_val = st_r.top;
            `TMR2_OFS_CMP0: rd_val = st_r.cmp[0];
            `TMR2_OFS_CMP1: rd_val = st_r.cmp[1];
            `TMR2_OFS_CTRL: rd_val[`TMR2_BIT_RUN] = st_r.run;
            `TMR2_OFS_CMPCFG0, `TMR2_OFS_CMPCFG1:
            begin
                rd_val[`TMR2_BIT_CMP_EN] = st_r.cmp_en[addr_i[4]]; // RULE13
                rd_val[`TMR2_BIT_CMP_INV] = st_r.cmp_inv[addr_i[4]];
                rd_val[`TMR2_MODE_HI:`TMR2_MODE_LO] = st_r.cmp_mode[addr_i[4]];
            end
            `TMR2_OFS_CAPCFG0, `TMR2_OFS_CAPCFG1:
            begin
                rd_val[`TMR2_BIT_CAP_FILT] = st_r.cap_filt[addr_i[2]]; // RULE13
                rd_val[`TMR2_EDGE_HI:`TMR2_EDGE_LO] = st_r.cap_edge[addr_i[2]];
            end
            `TMR2_OFS_FLAGS: rd_val = {9'h000, st_r.flags};
            `TMR2_OFS_FLAG_EN: rd_val = {9'h000, st_r.flag_en};
            default: rd_val = '0;
        endcase
    end

    // Counting, compare waveforms, flags and register writes
    always_comb
    begin
        st_nxt = st_r;
        wrap = 1'b0;
        // Count only while enabled; wrap at the threshold
        if (st_r.run) // RULE10
        begin
            if (st_r.count == st_r.top) // RULE3
            begin
                st_nxt.count = '0;
                wrap = 1'b1;
            end
            else
                st_nxt.count = st_r.count + 16'h0001;
        end
        // A counter write restarts wrap detection from the written value
        if (wr_i && addr_i == `TMR2_OFS_COUNT)
            wrap = 1'b0; // RULE2
        for (int i = 0; i < 2; i++)
        begin
            match[i] = st_r.run && (st_r.count == st_r.cmp[i]);
            case (st_r.cmp_mode[i]) // RULE5
                `TMR2_MODE_PWM: st_nxt.cmp_wave[i] = st_nxt.count < st_r.cmp[i];
                `TMR2_MODE_TOGGLE: st_nxt.cmp_wave[i] = st_r.cmp_wave[i] ^ match[i];
                `TMR2_MODE_SET:
                begin
                    if (match[i])
                        st_nxt.cmp_wave[i] = 1'b1;
                    else if (wrap)
                        st_nxt.cmp_wave[i] = 1'b0;
                end
                default: st_nxt.cmp_wave[i] = st_r.cmp_wave[i];
            endcase
        end
        evt = {cap_evt, st_r.run && (st_r.count == st_r.top),
               st_r.run && (st_r.count == 16'h0000), match, wrap};
        // Flags: write one to clear, a new event wins over the clear
        if (wr_i && addr_i == `TMR2_OFS_FLAGS)
            st_nxt.flags = st_r.flags & ~wdata_i[6:0];
        st_nxt.flags = st_nxt.flags | (evt & st_r.flag_en); // RULE11
        if (wr_i)
        begin
            case (addr_i)
                `TMR2_OFS_COUNT: st_nxt.count = wdata_i; // RULE2
                `TMR2_OFS_TOP: st_nxt.top = wdata_i; // RULE3
                `TMR2_OFS_CMP0: st_nxt.cmp[0] = wdata_i; // RULE6
                `TMR2_OFS_CMP1: st_nxt.cmp[1] = wdata_i; // RULE6
                `TMR2_OFS_CTRL: st_nxt.run = wdata_i[`TMR2_BIT_RUN];
                `TMR2_OFS_CMPCFG0, `TMR2_OFS_CMPCFG1:
                begin
                    st_nxt.cmp_en[addr_i[4]] = wdata_i[`TMR2_BIT_CMP_EN]; // RULE4
                    st_nxt.cmp_inv[addr_i[4]] = wdata_i[`TMR2_BIT_CMP_INV]; // RULE4
                    st_nxt.cmp_mode[addr_i[4]] = wdata_i[`TMR2_MODE_HI:`TMR2_MODE_LO];
                end
                `TMR2_OFS_CAPCFG0, `TMR2_OFS_CAPCFG1:
                begin
                    st_nxt.cap_filt[addr_i[2]] = wdata_i[`TMR2_BIT_CAP_FILT]; // RULE8
                    st_nxt.cap_edge[addr_i[2]] = wdata_i[`TMR2_EDGE_HI:`TMR2_EDGE_LO];
                end
                `TMR2_OFS_FLAG_EN: st_nxt.flag_en = wdata_i[6:0];
                default: st_nxt.run = st_nxt.run;
            endcase
        end
        st_nxt.rdata = rd_i ? rd_val : '0;
    end

    // State register with documented reset values
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r <= '0;
            st_r.top <= `TMR2_RST_TOP; // RULE3
            st_r.cmp <= {`TMR2_RST_ZERO, `TMR2_RST_ZERO}; // RULE6
        end
        else
            st_r <= st_nxt;
    end

    // Outputs held low while disabled
    assign cmp_out_o = st_r.cmp_en & (st_r.cmp_wave ^ st_r.cmp_inv); // RULE12
    assign rdata_o = st_r.rdata;
endmodule

// ### tmr2_params.svh
// Offsets, field positions, reset values and counts for the 16-bit timer block
// Notes on behaviour
// RULE1: A counter read returns the live count at the moment of the read.
// RULE2: A counter write replaces the count and restarts wrap detection from it.
// RULE3: A 16-bit read/write threshold sets the wrap limit; it resets to all ones.
// RULE4: Compare configuration bit 15 enables the output, bit 4 inverts it.
// RULE5: Compare configuration bits 3 to 0 select the output waveform mode.
// RULE6: Two 16-bit read/write compare values, one per channel, reset to zero.
// RULE7: Capture edge select bits 6:5: 0 off, 1 rising, 2 falling, 3 both.
// RULE8: Capture configuration bit 8 enables an input filter before edge detection.
// RULE9: Two read-only capture registers hold the count latched at the chosen edge.
// RULE10: Software clears counting enable before changing other settings; counting needs it set.
// RULE11: Separate pending flags for wrap, compares, zero, top and captures, each enable-gated.
// RULE12: A compare output with its enable clear stays at its inactive level.
// RULE13: Reserved configuration bits read zero and ignore writes; modes follow the mode list.
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH

`define TMR2_OFS_COUNT 16'h4580
`define TMR2_OFS_CAP0 16'h4582
`define TMR2_OFS_CAP1 16'h4584
`define TMR2_OFS_TOP 16'h4586
`define TMR2_OFS_CMP0 16'h4588
`define TMR2_OFS_CMP1 16'h458A
`define TMR2_OFS_CTRL 16'h458C
`define TMR2_OFS_CMPCFG0 16'h458E
`define TMR2_OFS_CMPCFG1 16'h4590
`define TMR2_OFS_CAPCFG0 16'h4592
`define TMR2_OFS_CAPCFG1 16'h4594
`define TMR2_OFS_FLAGS 16'h4596
`define TMR2_OFS_FLAG_EN 16'h4598

`define TMR2_BIT_RUN 11
`define TMR2_BIT_CMP_EN 15
`define TMR2_BIT_CMP_INV 4
`define TMR2_MODE_HI 3
`define TMR2_MODE_LO 0
`define TMR2_BIT_CAP_FILT 8
`define TMR2_EDGE_HI 6
`define TMR2_EDGE_LO 5

`define TMR2_RST_TOP 16'hFFFF
`define TMR2_RST_ZERO 16'h0000

`define TMR2_FLAG_WRAP 0
`define TMR2_FLAG_CMP0 1
`define TMR2_FLAG_ZERO 3
`define TMR2_FLAG_TOP 4
`define TMR2_FLAG_CAP0 5

`define TMR2_MODE_PWM 4'h0
`define TMR2_MODE_TOGGLE 4'h1
`define TMR2_MODE_SET 4'h2

`define TMR2_EDGE_RISE 2'h1
`define TMR2_EDGE_FALL 2'h2
`define TMR2_EDGE_BOTH 2'h3

`define TMR2_FILT_LEN 3

`endif

// ### tmr2_pkg.sv
// Types shared by the timer core and its capture channels
package tmr2_pkg;
    typedef logic [15:0] tmr2_word_t;

    typedef struct packed {
        tmr2_word_t count;
        tmr2_word_t top;
        tmr2_word_t [1:0] cmp;
        logic [1:0] cmp_en;
        logic [1:0] cmp_inv;
        logic [1:0][3:0] cmp_mode;
        logic [1:0] cmp_wave;
        logic [1:0] cap_filt;
        logic [1:0][1:0] cap_edge;
        logic run;
        logic [6:0] flags;
        logic [6:0] flag_en;
        tmr2_word_t rdata;
    } tmr2_core_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [2:0] hist;
        logic level;
        tmr2_word_t value;
    } tmr2_cap_t;
endpackage

// ### tmr2_cap_if.sv
// Signals between the timer core and one capture channel
`timescale 1ns/1ns
interface tmr2_cap_if;
    import tmr2_pkg::*;
    logic filt;
    logic [1:0] edge_sel;
    tmr2_word_t count;
    tmr2_word_t value;
    logic event_p;
    modport core (output filt, output edge_sel, output count, input value, input event_p);
    modport chan (input filt, input edge_sel, input count, output value, output event_p);
endinterface

// ### tmr2_capture.sv
// One capture channel: synchroniser, optional filter, edge select, latch
`timescale 1ns/1ns
`include "tmr2_params.svh"
module tmr2_capture
    import tmr2_pkg::*;
#(
    parameter int FILT_LEN = `TMR2_FILT_LEN
)(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    tmr2_cap_if.chan bus
);
    tmr2_cap_t st_r;
    tmr2_cap_t st_nxt;
    logic lvl;
    logic hit;

    // Refuse filter lengths that the three-sample history cannot serve
    if (FILT_LEN != 3)
    begin : g_bad_filt
        $error("tmr2_capture: filter history is three samples");
    end

    // Filter, edge detection and counter latch
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = pin_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.hist = {st_r.hist[1:0], st_r.sync2};
        lvl = st_r.level;
        if (!bus.filt)
            lvl = st_r.sync2;
        else if (&st_r.hist)
            lvl = 1'b1; // RULE8
        else if (~|st_r.hist)
            lvl = 1'b0; // RULE8
        st_nxt.level = lvl;
        case (bus.edge_sel)
            `TMR2_EDGE_RISE: hit = lvl & ~st_r.level; // RULE7
            `TMR2_EDGE_FALL: hit = ~lvl & st_r.level; // RULE7
            `TMR2_EDGE_BOTH: hit = lvl ^ st_r.level; // RULE7
            default: hit = 1'b0;
        endcase
        if (hit)
            st_nxt.value = bus.count; // RULE9
    end

    // State register
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign bus.value = st_r.value;
    assign bus.event_p = hit;
endmodule

// ### tmr2_timer_sva.sv
// Bus and compare-output assertions for the timer top module
`timescale 1ns/1ns
module tmr2_timer_sva (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [1:0] cmp_out_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    // Write followed at once by a read of the same place
    sequence wr_then_rd(logic [15:0] a);
        wr_i && addr_i == a ##1 rd_i && addr_i == a;
    endsequence
    property back(logic [15:0] a, logic [15:0] m);
        wr_then_rd(a) |=> rdata_o == ($past(wdata_i, 2) & m);
    endproperty
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not idle");
    count_rw_a: assert property (back(16'h4580, 16'hFFFF))
        else $error("count readback wrong");
    top_rw_a: assert property (back(16'h4586, 16'hFFFF))
        else $error("threshold readback wrong");
    cmp_first_a: assert property (back(16'h4588, 16'hFFFF))
        else $error("first compare readback wrong");
    cmp_second_a: assert property (back(16'h458A, 16'hFFFF))
        else $error("second compare readback wrong");
    cmp_cfg_a: assert property (back(16'h458E, 16'h801F))
        else $error("compare config readback wrong");
    cap_cfg_a: assert property (back(16'h4592, 16'h0160))
        else $error("capture config readback wrong");
    unmapped_a: assert property (rd_i && addr_i == 16'h4600 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    out_off_a: assert property (wr_i && addr_i == 16'h458E && !wdata_i[15] |=> !cmp_out_o[0])
        else $error("first output active while disabled");
    out_off_b_a: assert property (wr_i && addr_i == 16'h4590 && !wdata_i[15] |=> !cmp_out_o[1])
        else $error("second output active while disabled");
endmodule
bind tmr2_timer tmr2_timer_sva chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_out_o(cmp_out_o));

// ### tmr2_pin_model.sv
// Far side: drives the capture pins with a lag unrelated to the clock
`timescale 1ns/1ns
module tmr2_pin_model #(
    parameter int LAG_NS = 37
)(
    input wire logic [1:0] want_i,
    output logic [1:0] cap_pin_o
);
    // Pins follow the requested level after the lag
    initial cap_pin_o = 2'h0;
    always @(want_i)
    begin
        cap_pin_o <= #(LAG_NS) want_i;
    end
endmodule

// ### tb_top.sv
// Self-checking bench: registers, counting, capture edges, compare outputs
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top
    import tmr2_pkg::*;
;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_d = 1'b0;
    logic [1:0] want = 2'h0;
    logic [1:0] cap_pin_i;
    logic [1:0] cmp_out_o;
    logic [15:0] rdata_o;
    tmr2_word_t expq[$];
    tmr2_word_t cap[2];
    tmr2_word_t r;
    tmr2_word_t x;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 38;
    tmr2_timer dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_pin_i(cap_pin_i),
        .cmp_out_o(cmp_out_o));
    tmr2_pin_model pins (.want_i(want), .cap_pin_o(cap_pin_i));
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end
    function automatic tmr2_word_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    function automatic tmr2_word_t msk(input tmr2_word_t a);
        case (a)
            16'h4582, 16'h4584: return 16'h0000;
            16'h458E, 16'h4590: return 16'h801F;
            16'h4592, 16'h4594: return 16'h0160;
            16'h4598: return 16'h007F;
            default: return 16'hFFFF;
        endcase
    endfunction
    // One bus cycle; a read notes its expected data
    task automatic bus(input logic w, input tmr2_word_t a, input tmr2_word_t d);
        @(posedge mclk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        if (!w)
            expq.push_back(d);
    endtask
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge mclk_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Read data checked against the oldest note; hang limit
    always @(posedge mclk_i)
    begin
        rd_d <= rd_i;
        cyc++;
        if (rd_d)
        begin
            x = expq.pop_front();
            `CHK("rdata", x, rdata_o)
        end
        if (cyc == 3000)
        begin
            err_count++;
            test_done();
        end
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int a = 16'h4580; a <= 16'h4598; a += 2)
            bus(0, a[15:0], (a == 16'h4586) ? 16'hFFFF : 16'h0000);
        bus(0, 16'h4600, 16'h0000);
        for (int a = 16'h4580; a <= 16'h4598; a += 2)
        begin
            r = rnd();
            if (a != 16'h458C && a != 16'h4596)
            begin
                bus(1, a[15:0], r);
                bus(0, a[15:0], r & msk(a[15:0]));
            end
        end
        bus(1, 16'h4598, 16'h0001);
        bus(1, 16'h4596, 16'h007F);
        bus(1, 16'h4586, 16'h0005);
        bus(1, 16'h4588, 16'hFFFF);
        bus(1, 16'h458A, 16'h0000);
        bus(1, 16'h458E, 16'h0000);
        bus(1, 16'h4590, 16'h0000);
        bus(1, 16'h4580, 16'h0003);
        bus(1, 16'h458C, 16'h0800);
        for (int i = 0; i < 5; i++)
            bus(0, 16'h4580, 16'((3 + i) % 6));
        bus(1, 16'h4580, 16'h0001);
        bus(0, 16'h4580, 16'h0001);
        bus(0, 16'h4580, 16'h0002);
        bus(1, 16'h458C, 16'h0000);
        bus(0, 16'h4580, 16'h0004);
        bus(0, 16'h4596, 16'h0001);
        bus(1, 16'h4596, 16'h0001);
        bus(0, 16'h4596, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            bus(1, 16'h458E, {i[1], 10'h000, i[0], 4'h0});
            bus(1, 16'h4590, {i[1], 10'h000, i[0], 4'h0});
            idle(2);
            `CHK("cmp_out", {2{i[1]}} & (2'h1 ^ {2{i[0]}}), cmp_out_o)
        end
        cap = '{16'h0000, 16'h0000};
        for (int m = 0; m < 4; m++)
        begin
            bus(1, 16'h4592, 16'(m << 5));
            bus(1, 16'h4594, 16'(m << 5) | 16'h0100);
            for (int e = 1; e >= 0; e--)
            begin
                r = 16'h1000 + 16'(m * 2 + e);
                bus(1, 16'h4580, r);
                want <= {2{e[0]}};
                idle(12);
                if (m[1 - e])
                    cap = '{r, r};
                bus(0, 16'h4582, cap[0]);
                bus(0, 16'h4584, cap[1]);
            end
        end
        bus(1, 16'h4580, 16'h0777);
        want <= 2'h3;
        idle(1);
        want <= 2'h0;
        idle(12);
        bus(0, 16'h4582, 16'h0777);
        bus(0, 16'h4584, cap[1]);
        // Running compare modes and event flags: toggle on first, set and clear on second
        bus(1, 16'h4588, 16'h0002);
        bus(1, 16'h458A, 16'h0005);
        bus(1, 16'h4586, 16'h0007);
        bus(1, 16'h4580, 16'h0006);
        bus(1, 16'h458E, 16'h8001);
        bus(1, 16'h4590, 16'h8002);
        bus(1, 16'h4580, 16'h0000);
        bus(1, 16'h4598, 16'h007F);
        bus(1, 16'h4596, 16'h007F);
        for (int p = 0; p < 2; p++)
        begin
            bus(1, 16'h458C, 16'h0800);
            idle((p == 0) ? 5 : 3);
            bus(1, 16'h458C, 16'h0000);
            idle(2);
            `CHK("cmp_mode", (p == 0) ? 2'h3 : 2'h1, cmp_out_o)
            bus(0, 16'h4596, (p == 0) ? 16'h000E : 16'h001F);
        end
        bus(0, 16'h4580, 16'h0002);
        // Held level on both pins sets both capture flags
        want <= 2'h3;
        idle(12);
        bus(0, 16'h4596, 16'h007F);
        bus(0, 16'h4582, 16'h0002);
        bus(0, 16'h4584, 16'h0002);
        idle(3);
        test_done();
    end
endmodule
